// file: hw/chcc_regs.svh
// register offsets, reset values and timing counts of the charge current register bank
`ifndef CHCC_REGS_SVH
`define CHCC_REGS_SVH
`define CHCC_OFS_STATUS_CTRL 8'h00
`define CHCC_OFS_INPUT_CTRL 8'h01
`define CHCC_OFS_VOLTAGE_CTRL 8'h02
`define CHCC_OFS_IDENTITY 8'h03
`define CHCC_OFS_CURRENT 8'h04
`define CHCC_RST_STATUS_CTRL 8'h40
`define CHCC_RST_INPUT_CTRL 8'h30
`define CHCC_RST_VOLTAGE_CTRL 8'h0a
`define CHCC_RST_CURRENT 8'h89
`define CHCC_UNMAPPED_READ 8'hff
`define CHCC_CUR_RESET_BIT 7
`define CHCC_CUR_FAST_MSB 6
`define CHCC_CUR_FAST_LSB 4
`define CHCC_CUR_TERM_MSB 2
`define CHCC_CUR_TERM_LSB 0
`define CHCC_SAFETY_RESTART_BIT 7
`define CHCC_CLK_HZ 50000000
`define CHCC_SAFETY_TIME_MS 1000
`define CHCC_SAFETY_CYCLES (`CHCC_SAFETY_TIME_MS * (`CHCC_CLK_HZ / 1000))
`endif

// file: hw/chcc_pkg.sv
// types of the charge current register bank
package chcc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ACK_ADDR = 4'b0010,
    ST_REG = 4'b0011,
    ST_ACK_REG = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_ACK_WDATA = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_RACK = 4'b1000,
    ST_IGNORE = 4'b1001
  } chcc_state_t;
endpackage : chcc_pkg

// file: hw/chcc_safety_timer.sv
// safety timer that cannot be disabled and flags a stalled charge
`timescale 1ns/1ns
module chcc_safety_timer #(
  parameter int unsigned LIMIT = 32'd50000000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic restart_i,
  input wire logic stalled_i,
  output logic defective_o
);
  logic [31:0] count;
  logic defective;
  wire expired = stalled_i && (count >= LIMIT - 32'd1);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 32'h0;
    end else if (restart_i || !stalled_i) begin
      count <= 32'h0;
    end else if (!expired) begin
      count <= count + 32'd1;
    end
  end

  // no enable exists; expiry wins over a restart in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      defective <= 1'b0;
    end else if (expired) begin
      defective <= 1'b1;
    end else if (restart_i) begin
      defective <= 1'b0;
    end
  end

  assign defective_o = defective;
endmodule : chcc_safety_timer

// file: hw/chcc_top.sv
// serial-bus register bank for charge and termination current settings
// Operation
// - writing one to bit 7 resets charger
// - reset bit always reads back as one
// - bits 6:4 set fast charge current
// - bits 2:0 set termination current
// - current register at 04 resets to 89h
// - identity register 03 read-only, revision low bits
// - safety timer always on, flags defective battery
// - five byte registers, four writable, one read-only
// - unmapped register reads return ffh
// - write commits at end of data acknowledge
`timescale 1ns/1ns
`include "chcc_regs.svh"
module chcc_top #(
  parameter logic [6:0] DEV_ADDR = 7'h6b,
  // arbitrary identity value
  parameter logic [4:0] VENDOR_PART = 5'h12,
  // arbitrary revision value
  parameter logic [2:0] REVISION = 3'h2,
  parameter int unsigned SAFETY_CYCLES = `CHCC_SAFETY_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic charge_stalled_i,
  output logic [2:0] fast_charge_current_code_o,
  output logic [2:0] termination_current_code_o,
  output logic charger_reset_o,
  output logic battery_defective_o,
  output logic charge_terminate_o
);
  logic rst_meta;
  logic rst_n;
  logic scl_meta;
  logic scl_s;
  logic scl_d;
  logic sda_meta;
  logic sda_s;
  logic sda_d;
  chcc_pkg::chcc_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [7:0] reg_ptr;
  logic rw_read;
  logic drive_low;
  logic [7:0] status_ctrl;
  logic [7:0] input_ctrl;
  logic [7:0] voltage_ctrl;
  logic [6:0] current_cfg;
  logic charger_reset;
  logic timer_restart;
  logic [7:0] read_data;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_meta <= scl_i;
      scl_s <= scl_meta;
      scl_d <= scl_s;
      sda_meta <= sda_i;
      sda_s <= sda_meta;
      sda_d <= sda_s;
    end
  end

  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_cond = scl_s && scl_d && sda_d && !sda_s;
  wire stop_cond = scl_s && scl_d && !sda_d && sda_s;
  wire byte_done = scl_fall && (bit_cnt == 4'd8);
  wire addr_hit = (shreg[7:1] == DEV_ADDR);
  wire commit = scl_fall && (state == chcc_pkg::ST_ACK_WDATA);
  wire wr_status = commit && (reg_ptr == `CHCC_OFS_STATUS_CTRL);
  wire wr_input = commit && (reg_ptr == `CHCC_OFS_INPUT_CTRL);
  wire wr_voltage = commit && (reg_ptr == `CHCC_OFS_VOLTAGE_CTRL);
  wire wr_current = commit && (reg_ptr == `CHCC_OFS_CURRENT);

  // read selection; identity is fixed, unmapped reads all ones
  assign read_data = (reg_ptr == `CHCC_OFS_STATUS_CTRL) ? status_ctrl
    : (reg_ptr == `CHCC_OFS_INPUT_CTRL) ? input_ctrl
    : (reg_ptr == `CHCC_OFS_VOLTAGE_CTRL) ? voltage_ctrl
    : (reg_ptr == `CHCC_OFS_IDENTITY) ? {VENDOR_PART, REVISION}
    : (reg_ptr == `CHCC_OFS_CURRENT) ? {1'b1, current_cfg}
    : `CHCC_UNMAPPED_READ;

  // serial protocol engine
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= chcc_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      reg_ptr <= 8'h00;
      rw_read <= 1'b0;
      drive_low <= 1'b0;
    end else if (start_cond) begin
      state <= chcc_pkg::ST_ADDR;
      bit_cnt <= 4'h0;
      drive_low <= 1'b0;
    end else if (stop_cond) begin
      state <= chcc_pkg::ST_IDLE;
      drive_low <= 1'b0;
    end else begin
      case (state)
        chcc_pkg::ST_ADDR, chcc_pkg::ST_REG, chcc_pkg::ST_WDATA: begin
          if (scl_rise && bit_cnt < 4'd8) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'd1;
          end else if (byte_done) begin
            bit_cnt <= 4'h0;
            if (state == chcc_pkg::ST_ADDR) begin
              rw_read <= shreg[0];
              state <= addr_hit ? chcc_pkg::ST_ACK_ADDR : chcc_pkg::ST_IGNORE;
              drive_low <= addr_hit;
            end else if (state == chcc_pkg::ST_REG) begin
              reg_ptr <= shreg;
              state <= chcc_pkg::ST_ACK_REG;
              drive_low <= 1'b1;
            end else begin
              state <= chcc_pkg::ST_ACK_WDATA;
              drive_low <= 1'b1;
            end
          end
        end
        chcc_pkg::ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw_read) begin
              state <= chcc_pkg::ST_RDATA;
              txreg <= read_data;
              drive_low <= !read_data[7];
            end else begin
              state <= chcc_pkg::ST_REG;
              drive_low <= 1'b0;
            end
          end
        end
        chcc_pkg::ST_ACK_REG: begin
          if (scl_fall) begin
            state <= chcc_pkg::ST_WDATA;
            drive_low <= 1'b0;
          end
        end
        chcc_pkg::ST_ACK_WDATA: begin
          if (scl_fall) begin
            state <= chcc_pkg::ST_REG; // next pair is address then data
            drive_low <= 1'b0;
          end
        end
        chcc_pkg::ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'd1;
          end else if (byte_done) begin
            bit_cnt <= 4'h0;
            state <= chcc_pkg::ST_RACK;
            drive_low <= 1'b0;
          end else if (scl_fall) begin
            txreg <= {txreg[6:0], 1'b0};
            drive_low <= !txreg[6];
          end
        end
        chcc_pkg::ST_RACK: begin
          if (scl_rise && sda_s) begin
            state <= chcc_pkg::ST_IGNORE;
          end else if (scl_fall) begin
            state <= chcc_pkg::ST_RDATA;
            txreg <= read_data;
            drive_low <= !read_data[7];
          end
        end
        chcc_pkg::ST_IDLE, chcc_pkg::ST_IGNORE: begin
          drive_low <= 1'b0;
        end
        default: begin
          state <= chcc_pkg::ST_IDLE;
          drive_low <= 1'b0;
        end
      endcase
    end
  end

  // register file, written as the data acknowledge ends
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      status_ctrl <= `CHCC_RST_STATUS_CTRL;
      input_ctrl <= `CHCC_RST_INPUT_CTRL;
      voltage_ctrl <= `CHCC_RST_VOLTAGE_CTRL;
      current_cfg <= 7'(`CHCC_RST_CURRENT);
      charger_reset <= 1'b0;
      timer_restart <= 1'b0;
    end else begin
      if (wr_status) begin
        status_ctrl <= {1'b0, shreg[6:0]};
      end
      if (wr_input) begin
        input_ctrl <= shreg;
      end
      if (wr_voltage) begin
        voltage_ctrl <= shreg;
      end
      if (wr_current) begin
        current_cfg <= shreg[6:0];
      end
      charger_reset <= wr_current && shreg[`CHCC_CUR_RESET_BIT];
      timer_restart <= (wr_status && shreg[`CHCC_SAFETY_RESTART_BIT])
        || (wr_current && shreg[`CHCC_CUR_RESET_BIT]);
    end
  end

  chcc_safety_timer #(
    .LIMIT(SAFETY_CYCLES)
  ) u_timer (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .restart_i(timer_restart),
    .stalled_i(charge_stalled_i),
    .defective_o(battery_defective_o)
  );

  assign sda_o = 1'b0;
  assign sda_oe_n_o = !drive_low;
  assign fast_charge_current_code_o = current_cfg[`CHCC_CUR_FAST_MSB:`CHCC_CUR_FAST_LSB];
  assign termination_current_code_o = current_cfg[`CHCC_CUR_TERM_MSB:`CHCC_CUR_TERM_LSB];
  assign charger_reset_o = charger_reset;
  assign charge_terminate_o = battery_defective_o;
endmodule : chcc_top

// file: test/chcc_top_sva.sv
// port checker of the charge current register bank
`timescale 1ns/1ns
module chcc_top_sva #(
  parameter int unsigned SAFETY_CYCLES = 32'd20
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_oe_n_o,
  input wire logic charge_stalled_i,
  input wire logic [2:0] fast_charge_current_code_o,
  input wire logic [2:0] termination_current_code_o,
  input wire logic charger_reset_o,
  input wire logic battery_defective_o,
  input wire logic charge_terminate_o
);
  int unsigned stall_cnt;
  // a write may restart the timer, so bus activity clears the count
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stall_cnt <= 0;
    end else begin
      stall_cnt <= (charge_stalled_i && sda_oe_n_o) ? stall_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_PULSE_ONE: assert property (charger_reset_o |=> !charger_reset_o)
    else $error("reset pulse too long");
  AST_PULSE_AT_ACK: assert property (sda_oe_n_o [*8] |-> !charger_reset_o)
    else $error("reset pulse away from a write");
  AST_CODES_AT_ACK: assert property (sda_oe_n_o [*8] |->
    $stable(fast_charge_current_code_o) && $stable(termination_current_code_o))
    else $error("codes changed away from a write");
  AST_RESET_CODES: assert property ($rose(arst_n_i) |->
    (fast_charge_current_code_o == 3'h0 && termination_current_code_o == 3'h1) [*2])
    else $error("codes wrong after reset");
  AST_TERM_EQ: assert property (battery_defective_o == charge_terminate_o)
    else $error("terminate differs from defective");
  AST_TERM_CLEAR: assert property ($fell(charge_terminate_o) |-> !$past(sda_oe_n_o, 2))
    else $error("terminate cleared away from a write");
  AST_DEFECT_CAUSE: assert property ($rose(battery_defective_o) |-> $past(charge_stalled_i))
    else $error("defective without stall");
  AST_TIMER_EXPIRY: assert property (stall_cnt > SAFETY_CYCLES + 10 |-> battery_defective_o)
    else $error("timer did not expire");
  AST_SCL_HIGH_HOLD: assert property (scl_i [*3] |-> $stable(sda_oe_n_o))
    else $error("data changed while clock high");
endmodule : chcc_top_sva
bind chcc_top chcc_top_sva #(.SAFETY_CYCLES(SAFETY_CYCLES)) u_sva (.sys_clk_i(sys_clk_i),
  .arst_n_i(arst_n_i), .scl_i(scl_i), .sda_oe_n_o(sda_oe_n_o),
  .charge_stalled_i(charge_stalled_i), .fast_charge_current_code_o(fast_charge_current_code_o),
  .termination_current_code_o(termination_current_code_o), .charger_reset_o(charger_reset_o),
  .battery_defective_o(battery_defective_o), .charge_terminate_o(charge_terminate_o));

// file: test/chcc_host_model.sv
// serial bus host that programs the register bank
`timescale 1ns/1ns
module chcc_host_model #(
  parameter logic [6:0] DEV = 7'h6b
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic q(input int n);
    repeat (n) @(posedge clk_i);
  endtask : q
  // data moves only while the clock is low
  task automatic bit_x(input logic b, output logic r);
    scl_o <= 1'b0;
    q(2);
    sda_o <= b;
    q(6);
    scl_o <= 1'b1;
    q(3);
    r = sda_i;
    q(3);
  endtask : bit_x
  task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(a, k);
  endtask : byte_x
  task automatic st();
    scl_o <= 1'b0;
    q(2);
    sda_o <= 1'b1;
    q(6);
    scl_o <= 1'b1;
    q(6);
    sda_o <= 1'b0;
    q(6);
  endtask : st
  task automatic sp();
    scl_o <= 1'b0;
    q(2);
    sda_o <= 1'b0;
    q(6);
    scl_o <= 1'b1;
    q(6);
    sda_o <= 1'b1;
    q(6);
  endtask : sp
  task automatic wr(input logic [6:0] dev, input logic [7:0] rg, input logic [7:0] dt,
                    output logic nak);
    logic [7:0] x;
    logic a, b, c;
    st();
    byte_x({dev, 1'b0}, 1'b1, x, a);
    byte_x(rg, 1'b1, x, b);
    byte_x(dt, 1'b1, x, c);
    sp();
    nak = a | b | c;
  endtask : wr
  task automatic rd(input logic [7:0] rg, output logic [7:0] v);
    logic [7:0] x;
    logic a;
    st();
    byte_x({DEV, 1'b0}, 1'b1, x, a);
    byte_x(rg, 1'b1, x, a);
    st();
    byte_x({DEV, 1'b1}, 1'b1, x, a);
    byte_x(8'hff, 1'b1, v, a);
    sp();
  endtask : rd
endmodule : chcc_host_model

// file: test/charger_current_config_regs_bench.sv
// self-checking bench of the charge current register bank
`timescale 1ns/1ns
module charger_current_config_regs_bench;
  localparam logic [6:0] DEV = 7'h6b;
  localparam logic [7:0] IDENT = {5'h0c, 3'h5};
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic charge_stalled_i = 1'b0;
  logic scl, host_sda, sda_o, sda_oe_n_o, rst_pulse, defective, terminate, nak;
  logic [2:0] fast, term;
  logic [7:0] mem [5];
  logic [7:0] rv, d;
  int failures = 0;
  int tests_run = 0;
  int pulses = 0;
  int seed = 32'h50e9d845;
  int r, exp_pulses;
  wire logic sda_line = host_sda & (sda_oe_n_o | sda_o);
  always #10 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    if (rst_pulse === 1'b1) begin
      pulses <= pulses + 1;
    end
  end
  chcc_host_model #(.DEV(DEV)) HOST (.clk_i(sys_clk_i), .sda_i(sda_line), .scl_o(scl),
    .sda_o(host_sda));
  chcc_top #(.DEV_ADDR(DEV), .VENDOR_PART(5'h0c), .REVISION(3'h5), .SAFETY_CYCLES(20)) DUT (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .charge_stalled_i(charge_stalled_i),
    .fast_charge_current_code_o(fast), .termination_current_code_o(term),
    .charger_reset_o(rst_pulse), .battery_defective_o(defective),
    .charge_terminate_o(terminate));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("%0d failures in %0d comparisons", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk_codes(input logic [2:0] exp_fast, input logic [2:0] exp_term);
    chk({2'h0, fast, term}, {2'h0, exp_fast, exp_term});
  endtask : chk_codes
  task automatic chk_nak(input logic exp_nak);
    chk({7'h0, nak}, {7'h0, exp_nak});
  endtask : chk_nak
  task automatic chk_pulses(input int exp_cnt);
    chk(8'(pulses), 8'(exp_cnt));
  endtask : chk_pulses
  task automatic chk_flags(input logic exp_flag);
    chk({6'h0, defective, terminate}, {6'h0, exp_flag, exp_flag});
  endtask : chk_flags
  task automatic chk_rd(input int a);
    logic [7:0] e;
    HOST.rd(a[7:0], rv);
    e = (a == 3) ? IDENT : (a > 4) ? 8'hff : mem[a];
    chk(rv, e);
  endtask : chk_rd
  task automatic rst_seq();
    arst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    mem = '{8'h40, 8'h30, 8'h0a, 8'h00, 8'h89};
    repeat (6) @(posedge sys_clk_i);
    chk_codes(3'h0, 3'h1);
  endtask : rst_seq
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    failures++;
    finish_test();
  end
  initial begin
    rst_seq();
    for (r = 0; r < 6; r++) begin
      chk_rd(r);
    end
    for (int i = 0; i < 12; i++) begin
      r = (i < 2) ? 4 : {$random(seed)} % 6;
      d = (i == 0) ? 8'hf5 : (i == 1) ? 8'h3a : 8'($random(seed));
      exp_pulses = pulses + ((r == 4 && d[7]) ? 1 : 0);
      HOST.wr(DEV, r[7:0], d, nak);
      chk_nak(1'b0);
      if (r < 3) begin
        mem[r] = (r == 0) ? (d & 8'h7f) : d;
      end else if (r == 4) begin
        mem[4] = d | 8'h80;
      end
      repeat (10) @(posedge sys_clk_i);
      chk_codes(mem[4][6:4], mem[4][2:0]);
      chk_pulses(exp_pulses);
      chk_rd(r);
    end
    HOST.wr(7'h6a, 8'h04, 8'h00, nak);
    chk_nak(1'b1);
    chk_rd(4);
    charge_stalled_i <= 1'b1;
    repeat (40) @(posedge sys_clk_i);
    chk_flags(1'b1);
    charge_stalled_i <= 1'b0;
    exp_pulses = pulses + 1;
    HOST.wr(DEV, 8'h04, 8'h80, nak);
    mem[4] = 8'h80;
    repeat (10) @(posedge sys_clk_i);
    chk_flags(1'b0);
    chk_pulses(exp_pulses);
    rst_seq();
    chk_rd(4);
    finish_test();
  end
endmodule : charger_current_config_regs_bench
